// file: design/mafr_framer.sv
`default_nettype none
// Mode adaptation: packet CRC insertion and encapsulation header, bit-serial out
module mafr_framer
  import mafr_pkg::*;
#(
  parameter int unsigned FRAME_W = 14,
  parameter int unsigned BLOCK_W = 10
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Transport stream input, one byte per accepted cycle
  input  wire logic        in_valid_i,
  input  wire logic        in_sop_i,
  input  wire logic [7:0]  in_data_i,
  output logic             in_ready_o,
  // Satellite frame timing
  input  wire logic        frame_start_i,
  input  wire logic        service0_start_i,
  // Bit-serial output to stream adaptation
  output logic             out_valid_o,
  output logic             out_bit_o,
  output logic             out_sof_o,
  output logic             out_eof_o
);
  mafr_state_t state_r;
  mafr_state_t state_nxt;

  logic               in_ready_r;
  logic               out_valid_r;
  logic               out_bit_r;
  logic               out_sof_r;
  logic               out_eof_r;
  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;

  logic [31:0]        ctrl_r;
  logic [31:0]        frames_sent_r;
  logic [FRAME_W-1:0] frame_part_r;
  logic [BLOCK_W-1:0] block_part_r;
  logic [6:0]         bit_cnt_r;
  logic [7:0]         byte_cnt_r;
  logic [2:0]         pkt_cnt_r;
  logic               byte_full_r;
  logic               byte_full_nxt;

  logic               accept, last_bit_of_byte, svc_sync_en;
  logic               crc_init, crc_en, crc_bit, crc_shift;
  logic [15:0]        crc_val;
  logic               hdr_load, hdr_shift, hdr_msb;
  logic               byte_load, byte_shift, byte_msb;
  logic               emit, emit_bit, emit_sof, emit_eof;
  logic [1:0]         input_type;
  logic [HDR_BODY_BITS-1:0] hdr_body;

  assign accept      = in_valid_i && in_ready_r;
  assign svc_sync_en = ctrl_r[CTRL_SVC_BIT];
  assign input_type  = ctrl_r[CTRL_TYPE_LSB +: 2];
  assign last_bit_of_byte = (bit_cnt_r[2:0] == 3'h7);

  // Header body in transmit order; sync copy is the start byte being taken now
  assign hdr_body = {input_type,
                     PKT_LEN_BITS,
                     FIELD_LEN_BITS,
                     in_data_i,
                     RESERVED_VAL,
                     frame_part_r, block_part_r};

  // One CRC engine: header and packets never overlap in time
  mafr_crc16 u_crc (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .init_i  (crc_init),
    .en_i    (crc_en),
    .bit_i   (crc_bit),
    .shift_i (crc_shift),
    .crc_o   (crc_val)
  );

  mafr_shreg #(.W(HDR_BODY_BITS)) u_hdr_sh (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .load_i     (hdr_load),
    .load_val_i (hdr_body),
    .shift_i    (hdr_shift),
    .msb_o      (hdr_msb)
  );

  mafr_shreg #(.W(8)) u_byte_sh (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .load_i     (byte_load),
    .load_val_i (in_data_i),
    .shift_i    (byte_shift),
    .msb_o      (byte_msb)
  );

  // Sequencer: header body, header CRC, then eight packets with CRCs
  always_comb
  begin
    state_nxt     = state_r;
    crc_init      = 1'b0;
    crc_en        = 1'b0;
    crc_bit       = 1'b0;
    crc_shift     = 1'b0;
    hdr_load      = 1'b0;
    hdr_shift     = 1'b0;
    byte_load     = 1'b0;
    byte_shift    = 1'b0;
    emit          = 1'b0;
    emit_bit      = 1'b0;
    emit_sof      = 1'b0;
    emit_eof      = 1'b0;
    byte_full_nxt = byte_full_r;
    case (state_r)
      ST_IDLE:
      begin
        // Sync byte of the first packet is needed for the header
        if (accept && in_sop_i)
        begin
          hdr_load  = 1'b1;
          crc_init  = 1'b1;
          state_nxt = ST_HDR;
        end
      end
      ST_HDR:
      begin
        emit      = 1'b1;
        emit_bit  = hdr_msb;
        emit_sof  = (bit_cnt_r == 7'd0);
        crc_en    = 1'b1;
        crc_bit   = hdr_msb;
        hdr_shift = 1'b1;
        if (bit_cnt_r == 7'(HDR_BODY_BITS - 1))
          state_nxt = ST_HCRC;
      end
      ST_HCRC:
      begin
        emit      = 1'b1;
        emit_bit  = crc_val[15];
        crc_shift = 1'b1;
        if (bit_cnt_r == 7'(CRC_BITS - 1))
        begin
          crc_init  = 1'b1;
          state_nxt = ST_PKT;
        end
      end
      ST_PKT:
      begin
        if (byte_full_r)
        begin
          emit       = 1'b1;
          emit_bit   = byte_msb;
          crc_en     = 1'b1;
          crc_bit    = byte_msb;
          byte_shift = 1'b1;
          if (last_bit_of_byte)
          begin
            byte_full_nxt = 1'b0;
            if (byte_cnt_r == 8'(PAYLOAD_BYTES - 1))
              state_nxt = ST_PCRC;
          end
        end
        else if (accept)
        begin
          byte_load     = 1'b1;
          byte_full_nxt = 1'b1;
        end
      end
      ST_PCRC:
      begin
        emit      = 1'b1;
        emit_bit  = crc_val[15];
        crc_shift = 1'b1;
        if (bit_cnt_r == 7'(CRC_BITS - 1))
        begin
          if (pkt_cnt_r == 3'(PKTS_PER_FIELD - 1))
          begin
            emit_eof  = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
            state_nxt = ST_WSYNC;
        end
      end
      ST_WSYNC:
      begin
        // Sync byte is taken and dropped; bytes without a start mark resync
        if (accept && in_sop_i)
        begin
          crc_init  = 1'b1;
          state_nxt = ST_PKT;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bit counter restarts at each state change; in packets it wraps per byte
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      bit_cnt_r <= '0;
    else if (state_nxt != state_r)
      bit_cnt_r <= '0;
    else if (emit)
      bit_cnt_r <= (state_r == ST_PKT && last_bit_of_byte) ? 7'd0 : bit_cnt_r + 7'd1;
  end

  // Byte and packet counters
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      byte_cnt_r  <= '0;
      pkt_cnt_r   <= '0;
      byte_full_r <= 1'b0;
    end
    else
    begin
      byte_full_r <= byte_full_nxt;
      if (state_r != ST_PKT)
        byte_cnt_r <= '0;
      else if (byte_shift && last_bit_of_byte)
        byte_cnt_r <= byte_cnt_r + 8'd1;
      if (hdr_load)
        pkt_cnt_r <= '0;
      else if (state_r == ST_PCRC && state_nxt != ST_PCRC)
        pkt_cnt_r <= pkt_cnt_r + 3'd1;
    end
  end

  // Input ready only where a byte can be taken next cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      in_ready_r <= 1'b0;
    else
      in_ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_WSYNC) ||
                    (state_nxt == ST_PKT && !byte_full_nxt);
  end

  // Block part: used then advanced at each header; frame start wins
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      block_part_r <= '0;
    else if (frame_start_i)
      block_part_r <= '0;
    else if (hdr_load)
      block_part_r <= block_part_r + BLOCK_W'(1);
  end

  // Frame part follows satellite frames only with service sync on
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      frame_part_r <= '0;
    else if (!svc_sync_en)
      frame_part_r <= '0;
    else if (frame_start_i)
      frame_part_r <= service0_start_i ? '0 : frame_part_r + FRAME_W'(1);
  end

  // Output stage, all registered
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      out_valid_r <= 1'b0;
      out_bit_r   <= 1'b0;
      out_sof_r   <= 1'b0;
      out_eof_r   <= 1'b0;
    end
    else
    begin
      out_valid_r <= emit;
      out_bit_r   <= emit_bit;
      out_sof_r   <= emit_sof;
      out_eof_r   <= emit_eof;
    end
  end

  // Count of completed encapsulation frames, readable by software
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      frames_sent_r <= '0;
    else if (emit_eof)
      frames_sent_r <= frames_sent_r + 32'd1;
  end

  // APB: no wait states; pready answers in the first access cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pready_r <= 1'b0;
    else
      pready_r <= psel_i && !penable_i;
  end

  // Control register write; type and service-sync steer the header
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_r <= CTRL_RESET;
    else if (psel_i && penable_i && pready_r && pwrite_i && paddr_i == ADDR_CTRL)
      ctrl_r <= {29'h0, pwdata_i[2:0]};
  end

  // Read data and error prepared in the setup cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      case (paddr_i)
        ADDR_CTRL:
          prdata_r <= ctrl_r;
        ADDR_STATUS:
          prdata_r <= {1'b0, state_r, pkt_cnt_r, 1'b0, frame_part_r, block_part_r};
        ADDR_COUNT:
          prdata_r <= pwrite_i ? 32'h0 : frames_sent_r;
        default:
          pslverr_r <= 1'b1;  // Unmapped address
      endcase
      if (pwrite_i && paddr_i != ADDR_CTRL)
        pslverr_r <= 1'b1;  // Read-only or unmapped write
    end
  end

  assign in_ready_o  = in_ready_r;
  assign out_valid_o = out_valid_r;
  assign out_bit_o   = out_bit_r;
  assign out_sof_o   = out_sof_r;
  assign out_eof_o   = out_eof_r;
  assign prdata_o    = prdata_r;
  assign pready_o    = pready_r;
  assign pslverr_o   = pslverr_r;
endmodule
`default_nettype wire

// file: common/mafr_pkg.sv
// Summary of operation
// - A payload field holds exactly eight consecutive packets, each with its CRC.
// - Packet CRC-16 covers every byte after sync, polynomial 0x1021.
// - CRC is remainder of message times X^16 divided by generator.
// - CRC register preset to 0xffff before each packet's first bit.
// - Sync byte removed; CRC appended right after the packet's last byte.
// - Sync byte copied into an 8-bit header field, same for all packets.
// - A 114-bit header goes directly ahead of every payload field.
// - Header opens with 2-bit input type: 11 transport, 01 generic.
// - 16-bit packet length field in bits, 188 times 8 for transport.
// - 16-bit payload length field in bits, 12096 for transport.
// - Header carries a 32-bit reserved field.
// - 24-bit position counter: 14-bit frame part high, 10-bit block part low.
// - Without service synchronization the frame part stays zero.
// - With it, frame part counts frames, cleared at service-zero frames.
// - Block part zero for first encap frame, increments, cleared at frame start.
// - Header ends with CRC-16 over its first 98 bits, same preset.
// - Field order: type, lengths, sync, reserved, counter, CRC.
`default_nettype none
package mafr_pkg;
  // Packet and field geometry
  localparam int unsigned PKT_BYTES     = 188;
  localparam int unsigned PAYLOAD_BYTES = PKT_BYTES - 1;
  localparam int unsigned PKTS_PER_FIELD = 8;
  localparam int unsigned HDR_BITS      = 114;
  localparam int unsigned HDR_BODY_BITS = 98;
  localparam int unsigned CRC_BITS      = 16;

  // Header field values
  localparam logic [1:0]  TYPE_TS        = 2'h3;
  localparam logic [1:0]  TYPE_GENERIC   = 2'h1;
  localparam logic [15:0] PKT_LEN_BITS   = 16'h05e0;  // 188 x 8
  localparam logic [15:0] FIELD_LEN_BITS = 16'h2f40;  // 12096
  localparam logic [31:0] RESERVED_VAL   = 32'h0000_0000;

  // CRC
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hffff;

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT  = 12'h008;

  // Control register layout and reset
  localparam int unsigned CTRL_SVC_BIT  = 0;
  localparam int unsigned CTRL_TYPE_LSB = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0006;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_HCRC,
    ST_PKT,
    ST_PCRC,
    ST_WSYNC
  } mafr_state_t;
endpackage
`default_nettype wire

// file: design/mafr_crc16.sv
`default_nettype none
// Bit-serial CRC-16, MSB first, with shift-out mode for the result
module mafr_crc16
  import mafr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        init_i,
  input  wire logic        en_i,
  input  wire logic        bit_i,
  input  wire logic        shift_i,
  output logic      [15:0] crc_o
);
  logic [15:0] crc_r;

  // Preset wins over shifting so a new message never inherits old state
  always_ff @(posedge clk_i)
  begin
    if (reset_i || init_i)
      crc_r <= CRC_PRESET;
    else if (en_i)
      crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ bit_i) ? CRC_POLY : 16'h0000);
    else if (shift_i)
      crc_r <= {crc_r[14:0], 1'b0};
  end

  assign crc_o = crc_r;
endmodule
`default_nettype wire

// file: design/mafr_shreg.sv
`default_nettype none
// Parallel-load, MSB-first shift register
module mafr_shreg #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         shift_i,
  output logic              msb_o
);
  logic [W-1:0] sh_r;

  // Load has priority; shifting inserts zeros at the bottom
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sh_r <= '0;
    else if (load_i)
      sh_r <= load_val_i;
    else if (shift_i)
      sh_r <= {sh_r[W-2:0], 1'b0};
  end

  assign msb_o = sh_r[W-1];
endmodule
`default_nettype wire

// file: tb/mafr_checker_assertions.sv
`default_nettype none
// Frame-shape checks on the serial output and the byte handshake
module mafr_checker
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic in_valid_i,
  input  wire logic in_sop_i,
  input  wire logic in_ready_o,
  input  wire logic out_valid_o,
  input  wire logic out_sof_o,
  input  wire logic out_eof_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME_BITS = 12210;
  int unsigned cnt_r;
  logic        in_frame_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Bit position in frame; the sof bit counts as the first
  always_ff @(posedge clk_i)
    if (reset_i)
      cnt_r <= 0;
    else if (out_sof_o)
      cnt_r <= 1;
    else if (out_valid_o)
      cnt_r <= cnt_r + 1;

  // Inside a frame from sof until eof
  always_ff @(posedge clk_i)
    if (reset_i)
      in_frame_r <= 1'b0;
    else if (out_sof_o)
      in_frame_r <= 1'b1;
    else if (out_eof_o)
      in_frame_r <= 1'b0;

  sequence s_hdr_lead;
    out_valid_o [*8];
  endsequence

  property p_sof_valid;
    out_sof_o |-> out_valid_o && !out_eof_o;
  endproperty
  property p_sof_burst;
    out_sof_o |=> s_hdr_lead;
  endproperty
  property p_eof_len;
    out_eof_o |-> out_valid_o && cnt_r == FRAME_BITS - 1;
  endproperty
  property p_hdr_run;
    in_frame_r && cnt_r < 114 |-> out_valid_o;
  endproperty
  property p_hdr_stall;
    in_frame_r && cnt_r < 100 |-> !in_ready_o;
  endproperty
  property p_sof_whole;
    out_sof_o |-> !in_frame_r;
  endproperty
  property p_eof_next;
    out_eof_o |-> ##[0:4] in_ready_o;
  endproperty
  property p_byte_pace;
    in_frame_r && in_valid_i && in_ready_o && !in_sop_i |=> !in_ready_o;
  endproperty

  a_sof_valid: assert property (p_sof_valid) else $error("sof without valid");
  a_sof_burst: assert property (p_sof_burst) else $error("header gap");
  a_eof_len: assert property (p_eof_len) else $error("frame length wrong");
  a_hdr_run: assert property (p_hdr_run) else $error("header not contiguous");
  a_hdr_stall: assert property (p_hdr_stall) else $error("byte taken in header");
  a_sof_whole: assert property (p_sof_whole) else $error("sof inside frame");
  a_eof_next: assert property (p_eof_next) else $error("no ready after eof");
  a_byte_pace: assert property (p_byte_pace) else $error("ready held");
endmodule

bind mafr_framer mafr_checker mafr_checker_i (
  .clk_i       (clk_i),
  .reset_i     (reset_i),
  .in_valid_i  (in_valid_i),
  .in_sop_i    (in_sop_i),
  .in_ready_o  (in_ready_o),
  .out_valid_o (out_valid_o),
  .out_sof_o   (out_sof_o),
  .out_eof_o   (out_eof_o)
);
`default_nettype wire

// file: tb/mafr_ts_source.sv
`default_nettype none
// Packet source; random idle gaps when slow
module mafr_ts_source
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       slow_i,
  input  wire logic       ready_i,
  output logic            valid_o,
  output logic            sop_o,
  output logic      [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         seed = 32'h2b87;
  int         idx;
  logic [7:0] sent_q[$];

  // New byte only after the last was taken; hold it otherwise
  always @(posedge clk_i)
    if (reset_i)
    begin
      valid_o <= 1'b0;
      sop_o <= 1'b0;
      data_o <= 8'h00;
      idx <= 0;
    end
    else if (!valid_o || ready_i)
    begin
      if (valid_o)
        sent_q.push_back(data_o);
      if (slow_i && $random(seed) % 8 == 0)
      begin
        valid_o <= 1'b0;
        data_o <= ~data_o; // Idle bus inverts the held byte; every second idle cycle shows the stale byte again
      end
      else
      begin
        valid_o <= 1'b1;
        sop_o <= (idx == 0);
        data_o <= (idx == 0) ? 8'h47 : 8'($random(seed));
        idx <= (idx == 187) ? 0 : idx + 1;
      end
    end
endmodule
`default_nettype wire

// file: tb/mafr_framer_bench.sv
`default_nettype none
module mafr_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, err;
  logic        fs, s0, slow, iv, isop, irdy, ov, ob, osof, oeof;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  idat;
  int          miscompares, n_compared;
  logic        q_bits[$];
  int          sof_q[$];
  logic [1:0]  e_ty[4] = '{2'h3, 2'h3, 2'h1, 2'h1};
  logic [13:0] e_fr[4] = '{14'h0, 14'h0, 14'h0, 14'h1};
  logic [9:0]  e_bk[4] = '{10'h0, 10'h0, 10'h1, 10'h0};

  mafr_framer mafr_framer_i (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .in_valid_i(iv),
    .in_sop_i(isop), .in_data_i(idat), .in_ready_o(irdy), .frame_start_i(fs),
    .service0_start_i(s0), .out_valid_o(ov), .out_bit_o(ob), .out_sof_o(osof),
    .out_eof_o(oeof));
  mafr_ts_source mafr_ts_source_i (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow),
    .ready_i(irdy), .valid_o(iv), .sop_o(isop), .data_o(idat));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Collect serial bits, noting where each frame starts
  always @(posedge clk_i)
    if (!reset_i && ov === 1'b1)
    begin
      if (osof)
        sof_q.push_back(q_bits.size());
      q_bits.push_back(ob);
    end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
  endfunction

  function automatic logic [127:0] take(input int pos, input int n);
    logic [127:0] v;
    v = '0;
    for (int i = 0; i < n; i++)
      v = {v[126:0], q_bits[pos + i]};
    return v;
  endfunction

  task automatic check_frame(input int f);
    logic [97:0] hb;
    logic [15:0] c;
    logic [7:0]  b;
    int          pos;
    hb = {e_ty[f], 16'h05e0, 16'h2f40, 8'h47, 32'h0, e_fr[f], e_bk[f]};
    c = 16'hffff;
    for (int i = 97; i >= 0; i--)
      c = crc_bit(c, hb[i]);
    pos = f * 12210;
    check(sof_q[f], pos);
    check(take(pos, 114), {hb, c});
    pos += 114;
    for (int p = 0; p < 8; p++)
    begin
      c = 16'hffff;
      for (int j = 1; j < 188; j++)
      begin
        b = mafr_ts_source_i.sent_q[(f * 8 + p) * 188 + j];
        for (int i = 7; i >= 0; i--)
          c = crc_bit(c, b[i]);
        check(take(pos, 8), b);
        pos += 8;
      end
      check(take(pos, 16), c);
      pos += 16;
    end
    $display("frame %0d checked", f);
  endtask

  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic svc0);
    @(posedge clk_i);
    fs <= 1'b1;
    s0 <= svc0;
    @(posedge clk_i);
    fs <= 1'b0;
  endtask

  // Only the watchdog ends a wait that never completes
  task automatic wait_sof(input int f);
    while (sof_q.size() <= f)
      @(posedge clk_i);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog sized for four frames with idle gaps
  initial
  begin
    #(8 * 90000);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, fs, s0, slow} = '0;
    reset_i = 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h6);
    apb(1'b0, 12'h00c, 32'h0);
    check({rd, err}, 33'h1);
    apb(1'b1, 12'h004, 32'h5);
    check(err, 1'b1);
    $display("register test done");
    // Frame pulse with service sync off must leave frame part at zero
    wait_sof(0);
    pulse(1'b0);
    wait_sof(1);
    slow <= 1'b1;
    apb(1'b1, 12'h000, 32'h3);
    wait_sof(2);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b0);
    wait_sof(3);
    while (q_bits.size() < 4 * 12210)
      @(posedge clk_i);
    // Fifth frame cannot end yet, so exactly four are counted
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h4);
    for (int f = 0; f < 4; f++)
      check_frame(f);
    tally_and_finish();
  end
endmodule
`default_nettype wire
